//--- core/port_power_pkg.sv
// Constants and carrier types for the hub port power and boot-strap control.
// Assumes a single 20 MHz clock domain and no register bus; all controls are ports.
package port_power_pkg;

  // Number of downstream ports
  localparam int unsigned NUM_PORTS = 4;

  // Reset values
  localparam logic POLARITY_HIGH_RESET = 1'h0;
  localparam logic [1:0] SYNC_RESET = 2'h0;
  localparam logic [3:0] SYNC_PORTS_RESET = 4'hF;

  // Code source picked by the strap
  typedef enum logic [1:0] {
    BOOT_PENDING = 2'b00,
    BOOT_ROM = 2'b01,
    BOOT_FLASH = 2'b10
  } boot_state_t;

  // Synchronised status, over-current bits polarity-corrected
  typedef struct packed {
    logic [3:0] overcurrent;
    logic upstream_vbus_present;
    logic self_powered;
  } power_status_t;

  // SPI master pin group, drive value and output enable per output pin, enable only for MISO
  typedef struct packed {
    logic sck_out;
    logic sck_oe;
    logic cs_out;
    logic cs_oe;
    logic mosi_out;
    logic mosi_oe;
    logic miso_oe;
  } spi_pins_t;

endpackage : port_power_pkg

//--- core/port_power_control.sv
// Port power switch control, over-current sensing and boot-strap capture.
// Assumes inputs synchronous to sys_clk after two flops; SPI engine sits outside.
`timescale 1ns/1ps
`default_nettype none
module port_power_control
  import port_power_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic polarity_active_high,
  input wire logic power_switch_mode,
  input wire logic [3:0] port_power_request,
  input wire logic [3:0] port_overcurrent_flag,
  input wire logic upstream_vbus_detect,
  input wire logic self_power_detect,
  output logic [3:0] port_power_enable_out,
  output logic [3:0] port_power_enable_oe,
  output logic [3:0] overcurrent_pullup_en,
  output logic [3:0] overcurrent_led,
  output var power_status_t status,
  input wire logic flash_chip_select_strap_in,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic flash_miso_in,
  output logic spi_miso,
  output var spi_pins_t spi_pins,
  output logic boot_from_flash,
  output logic boot_valid
);

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; first stage feeds only the second
  logic [3:0] oc_meta;
  logic [3:0] oc_sync;
  logic [1:0] det_meta;
  logic [1:0] det_sync;
  logic polarity;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      oc_meta <= SYNC_PORTS_RESET;
      oc_sync <= SYNC_PORTS_RESET;
      det_meta <= SYNC_RESET;
      det_sync <= SYNC_RESET;
    end else begin
      oc_meta <= port_overcurrent_flag;
      oc_sync <= oc_meta;
      det_meta <= {upstream_vbus_detect, self_power_detect};
      det_sync <= det_meta;
    end
  end

  // Polarity register; firmware changes it, reset forces active low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      polarity <= POLARITY_HIGH_RESET;
    end else begin
      polarity <= polarity_active_high;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status: polarity applied to the over-current bits only, after synchronising
  power_status_t next_status;

  always_comb begin
    next_status.overcurrent = polarity ? oc_sync : ~oc_sync;
    next_status.upstream_vbus_present = det_sync[1];
    next_status.self_powered = det_sync[0];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status <= '0;
      overcurrent_led <= 4'h0;
    end else begin
      status <= next_status;
      overcurrent_led <= next_status.overcurrent;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power enables; open-drain only pulls low, push-pull drives both levels
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port_power_enable_out <= 4'h0;
      port_power_enable_oe <= 4'h0;
    end else if (polarity) begin
      port_power_enable_out <= port_power_request;
      port_power_enable_oe <= 4'hF;
    end else begin
      port_power_enable_out <= 4'h0;
      port_power_enable_oe <= port_power_request;
    end
  end

  // Pull-ups only meaningful with power switches attached
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      overcurrent_pullup_en <= 4'h0;
    end else begin
      overcurrent_pullup_en <= power_switch_mode ? 4'hF : 4'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Strap capture: sampled on the first clock after reset release
  boot_state_t boot_state;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      boot_state <= BOOT_PENDING;
    end else begin
      case (boot_state)
        BOOT_PENDING: begin
          boot_state <= flash_chip_select_strap_in ? BOOT_FLASH : BOOT_ROM;
        end
        BOOT_ROM: boot_state <= BOOT_ROM;
        BOOT_FLASH: boot_state <= BOOT_FLASH;
        default: boot_state <= BOOT_PENDING;
      endcase
    end
  end

  assign boot_valid = (boot_state != BOOT_PENDING);
  assign boot_from_flash = (boot_state == BOOT_FLASH);

  //////////////////////////////////////////////////////////////////////////////
  // SPI master pins; released while the strap is being read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      spi_pins <= '0;
      spi_miso <= 1'h0;
    end else begin
      spi_pins.sck_out <= spi_sck;
      spi_pins.cs_out <= spi_cs_n;
      spi_pins.mosi_out <= spi_mosi;
      spi_pins.sck_oe <= boot_valid;
      spi_pins.cs_oe <= boot_valid;
      spi_pins.mosi_oe <= boot_valid;
      spi_pins.miso_oe <= 1'h0;
      spi_miso <= flash_miso_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_oc_seen;
    !port_overcurrent_flag[0] && !polarity;
  endsequence

  a_oc_led_follow: assert property (@(posedge sys_clk) disable iff (rst)
    s_oc_seen ##1 !polarity [*3] |-> overcurrent_led[0])
    else $error("over-current led late");
  a_oc_status_pol: assert property (@(posedge sys_clk) disable iff (rst)
    $past(polarity) == polarity |-> status.overcurrent == (polarity ? $past(oc_sync) : ~$past(oc_sync)))
    else $error("over-current polarity wrong");
  a_od_never_high: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(polarity) |-> port_power_enable_out == 4'h0)
    else $error("open drain drove high");
  a_pp_all_driven: assert property (@(posedge sys_clk) disable iff (rst)
    $past(polarity) |-> port_power_enable_oe == 4'hF)
    else $error("push pull not driven");
  a_enable_on_low: assert property (@(posedge sys_clk) disable iff (rst)
    !polarity && port_power_request[0] ##1 !$past(polarity) |-> port_power_enable_oe[0])
    else $error("port not powered");
  a_vbus_detect: assert property (@(posedge sys_clk) disable iff (rst)
    upstream_vbus_detect [*4] |-> status.upstream_vbus_present)
    else $error("vbus detect missed");
  a_self_power: assert property (@(posedge sys_clk) disable iff (rst)
    !self_power_detect [*4] |-> !status.self_powered)
    else $error("self power wrong");
  a_strap_once: assert property (@(posedge sys_clk) disable iff (rst)
    boot_valid |=> boot_valid && $stable(boot_from_flash))
    else $error("strap changed");
  a_spi_drive: assert property (@(posedge sys_clk) disable iff (rst)
    boot_valid |=> spi_pins.sck_oe && spi_pins.cs_oe && !spi_pins.miso_oe)
    else $error("spi pins not driven");
  a_pullup_mode: assert property (@(posedge sys_clk) disable iff (rst)
    !power_switch_mode |=> overcurrent_pullup_en == 4'h0)
    else $error("pull-up active outside mode");
  a_sync_delay: assert property (@(posedge sys_clk) disable iff (rst)
    oc_sync == $past(port_overcurrent_flag, 2) || $past(rst, 2))
    else $error("synchroniser depth wrong");

  //////////////////////////////////////////////////////////////////////////////
  // Further checks: the other level and polarity of each input, and pin release
  sequence s_oc_high_seen;
    port_overcurrent_flag[3] && polarity;
  endsequence

  sequence s_oc_clear_low;
    port_overcurrent_flag[0] && !polarity;
  endsequence

  a_oc_led_high: assert property (@(posedge sys_clk) disable iff (rst)
    s_oc_high_seen ##1 polarity [*3] |-> overcurrent_led[3])
    else $error("active-high over-current missed");
  a_oc_led_clear: assert property (@(posedge sys_clk) disable iff (rst)
    s_oc_clear_low ##1 !polarity [*3] |-> !overcurrent_led[0])
    else $error("false over-current led");
  a_pp_follow: assert property (@(posedge sys_clk) disable iff (rst)
    polarity |=> port_power_enable_out == $past(port_power_request))
    else $error("push pull level wrong");
  a_enable_off_low: assert property (@(posedge sys_clk) disable iff (rst)
    !polarity && !port_power_request[0] |=> !port_power_enable_oe[0] && !port_power_enable_out[0])
    else $error("port powered without request");
  a_vbus_absent: assert property (@(posedge sys_clk) disable iff (rst)
    !upstream_vbus_detect [*4] |-> !status.upstream_vbus_present)
    else $error("vbus absent missed");
  a_self_powered: assert property (@(posedge sys_clk) disable iff (rst)
    self_power_detect [*4] |-> status.self_powered)
    else $error("self power missed");
  a_boot_capture: assert property (@(posedge sys_clk) disable iff (rst)
    !boot_valid |=> boot_valid && boot_from_flash == $past(flash_chip_select_strap_in))
    else $error("strap not captured");
  a_spi_released: assert property (@(posedge sys_clk) disable iff (rst)
    !boot_valid |=> !spi_pins.sck_oe && !spi_pins.cs_oe && !spi_pins.mosi_oe && !spi_pins.miso_oe)
    else $error("flash pins driven during strap");
  a_spi_follow: assert property (@(posedge sys_clk) disable iff (rst)
    boot_valid |=> spi_pins.sck_out == $past(spi_sck) && spi_pins.cs_out == $past(spi_cs_n)
      && spi_pins.mosi_out == $past(spi_mosi) && spi_miso == $past(flash_miso_in))
    else $error("flash pins not following");
  a_pullup_on: assert property (@(posedge sys_clk) disable iff (rst)
    power_switch_mode |=> overcurrent_pullup_en == 4'hF)
    else $error("pull-up missing in mode");

endmodule : port_power_control
`default_nettype wire

//--- verif/vbus_switch_model.sv
// Far-side model: four VBUS power switches and their fault flag outputs.
// Assumes enable pins split into drive value and output enable.
`timescale 1ns/1ps
`default_nettype none
module vbus_switch_model (
  input wire logic pol_high,
  input wire logic [3:0] en_out,
  input wire logic [3:0] en_oe,
  input wire logic [3:0] fault,
  output logic [3:0] vbus_on,
  output logic [3:0] oc_pin
);
  logic [3:0] pin;
  // Released enable floats high through the board pull-up
  assign pin = (en_out & en_oe) | ~en_oe;
  // Switch turns on at the configured active level
  assign vbus_on = pol_high ? pin : ~pin;
  // Fault flag follows the same polarity setting
  assign oc_pin = pol_high ? fault : ~fault;
endmodule : vbus_switch_model
`default_nettype wire

//--- verif/tb_port_power_control.sv
// Bench for port power control: enables, faults, detects, strap, SPI pins.
// Assumes the switch model on the enable pins; SPI engine side driven here.
`timescale 1ns/1ps
`default_nettype none
module tb_port_power_control;
  import port_power_pkg::*;
  logic sys_clk, rst, polarity_active_high, power_switch_mode;
  logic upstream_vbus_detect, self_power_detect, flash_chip_select_strap_in;
  logic spi_sck, spi_cs_n, spi_mosi, flash_miso_in, spi_miso, boot_from_flash, boot_valid;
  logic [3:0] port_power_request, port_overcurrent_flag, port_power_enable_out;
  logic [3:0] port_power_enable_oe, overcurrent_pullup_en, overcurrent_led, fault, vbus;
  power_status_t status;
  spi_pins_t spi_pins;
  int n_errors = 0;
  int samples_checked = 0;
  port_power_control i_dut (.sys_clk, .rst, .polarity_active_high, .power_switch_mode,
    .port_power_request, .port_overcurrent_flag, .upstream_vbus_detect, .self_power_detect,
    .port_power_enable_out, .port_power_enable_oe, .overcurrent_pullup_en, .overcurrent_led,
    .status, .flash_chip_select_strap_in, .spi_sck, .spi_cs_n, .spi_mosi, .flash_miso_in,
    .spi_miso, .spi_pins, .boot_from_flash, .boot_valid);
  vbus_switch_model i_sw (.pol_high(polarity_active_high), .en_out(port_power_enable_out),
    .en_oe(port_power_enable_oe), .fault(fault), .vbus_on(vbus), .oc_pin(port_overcurrent_flag));
  ////////////////////////////////////////////////////////////////////////////
  // 50 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Inputs move 1 ns after the edge, never on it
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic reset_with(input logic s);
    flash_chip_select_strap_in = s;
    rst = 1'b1;
    tick(20);
    rst = 1'b0;
    tick(1);
    chk(8'({spi_pins.sck_oe, spi_pins.cs_oe, spi_pins.mosi_oe, boot_valid}), 8'h01);
    tick(1);
    flash_chip_select_strap_in = ~s;
    tick(2);
  endtask : reset_with
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////
  // Tests; a strap flip after sampling must not change the boot source
  initial begin
    {polarity_active_high, power_switch_mode, upstream_vbus_detect, self_power_detect} = 4'h0;
    {spi_sck, spi_cs_n, spi_mosi, flash_miso_in, flash_chip_select_strap_in} = 5'h0;
    port_power_request = 4'h0;
    fault = 4'h0;
    rst = 1'b1;
    reset_with(1'b1);
    chk(8'({boot_valid, boot_from_flash}), 8'h03);
    reset_with(1'b0);
    chk(8'({boot_valid, boot_from_flash}), 8'h02);
    $display("done: strap");
    port_power_request = 4'h5;
    tick(1);
    chk({port_power_enable_oe, port_power_enable_out}, 8'h50);
    chk(8'(vbus), 8'h05);
    // Ports 0 and 1 faulted, so the active-low led assertion on port 0 is exercised
    fault = 4'h3;
    tick(2);
    chk(8'(overcurrent_led), 8'h00);
    tick(1);
    chk({status.overcurrent, overcurrent_led}, 8'h33);
    {upstream_vbus_detect, self_power_detect, power_switch_mode} = 3'h5;
    tick(3);
    chk(8'({status.upstream_vbus_present, status.self_powered}), 8'h02);
    chk(8'(overcurrent_pullup_en), 8'h0F);
    {upstream_vbus_detect, self_power_detect, power_switch_mode} = 3'h2;
    tick(3);
    chk(8'({status.upstream_vbus_present, status.self_powered}), 8'h01);
    chk(8'(overcurrent_pullup_en), 8'h00);
    $display("done: active low");
    polarity_active_high = 1'b1;
    port_power_request = 4'hA;
    fault = 4'h8;
    tick(4);
    chk({port_power_enable_oe, port_power_enable_out}, 8'hFA);
    chk(8'(vbus), 8'h0A);
    chk({status.overcurrent, overcurrent_led}, 8'h88);
    $display("done: active high");
    {spi_sck, spi_cs_n, spi_mosi, flash_miso_in} = 4'hB;
    tick(2);
    chk(8'({spi_pins, spi_miso}), 8'hDD);
    $display("done: flash pins");
    stop_test();
  end
  // Watchdog far beyond the 64 cycles the tests need
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    stop_test();
  end
endmodule : tb_port_power_control
`default_nettype wire
